// ---- logic/fperr_pkg.sv ----
// Package of constants and types for the floating-point error signalling unit.
package fperr_pkg;

  localparam int unsigned FLAG_W = 6;
  localparam logic [7:0] NUMERIC_VECTOR = 8'h10;
  localparam logic [7:0] DNA_VECTOR = 8'h07;
  localparam logic [7:0] ALIGN_VECTOR = 8'h0D;
  localparam logic [9:0] LEGACY16_BYTES = 10'h05E;
  localparam logic [9:0] LEGACY32_BYTES = 10'h06C;
  localparam logic [9:0] EXTENDED_BYTES = 10'h200;
  localparam logic [3:0] EXT_ALIGN_MASK = 4'hF;
  localparam logic [FLAG_W-1:0] FLAGS_RESET = 6'h00;
  localparam logic [FLAG_W-1:0] MASKS_RESET = 6'h3F;
  localparam logic [2:0] TAG_LEGACY_FMT = 3'h0;
  localparam logic [2:0] TAG_EXTENDED_FMT = 3'h1;

  typedef enum logic [3:0] {
    FPERR_OP_NONE = 4'h0,
    FPERR_OP_ARITH = 4'h1,
    FPERR_OP_WAIT = 4'h2,
    FPERR_OP_NOWAIT = 4'h3,
    FPERR_OP_LSAVE = 4'h4,
    FPERR_OP_LSAVE_NW = 4'h5,
    FPERR_OP_LRESTORE = 4'h6,
    FPERR_OP_XSAVE = 4'h7,
    FPERR_OP_XRESTORE = 4'h8,
    FPERR_OP_CLEAR = 4'h9
  } fperr_op_e;

  typedef enum logic [1:0] {
    FPERR_ST_IDLE = 2'h0,
    FPERR_ST_PULSE = 2'h1
  } fperr_state_e;

endpackage

// ---- logic/fperr_if.sv ----
// Interface carrying a decoded instruction from the top to the image sizer.
interface fperr_if;
  logic valid;
  fperr_pkg::fperr_op_e op;
  logic mode32;
  logic [31:0] addr;
  logic [9:0] bytes;
  logic [2:0] tag_fmt;
  logic misaligned;
  modport src (output valid, output op, output mode32, output addr,
               input bytes, input tag_fmt, input misaligned);
  modport sink (input valid, input op, input mode32, input addr,
                output bytes, output tag_fmt, output misaligned);
endinterface

// ---- logic/fperr_image.sv ----
// Combinational sizer for state save and restore memory images.
module fperr_image (
  fperr_if.sink req
);

  always_comb begin
    req.bytes = 10'h000;
    req.tag_fmt = fperr_pkg::TAG_LEGACY_FMT;
    req.misaligned = 1'b0;
    case (req.op)
      fperr_pkg::FPERR_OP_LSAVE, fperr_pkg::FPERR_OP_LSAVE_NW,
      fperr_pkg::FPERR_OP_LRESTORE: begin
        req.bytes = req.mode32 ? fperr_pkg::LEGACY32_BYTES
                               : fperr_pkg::LEGACY16_BYTES;
      end
      fperr_pkg::FPERR_OP_XSAVE, fperr_pkg::FPERR_OP_XRESTORE: begin
        req.bytes = fperr_pkg::EXTENDED_BYTES;
        req.tag_fmt = fperr_pkg::TAG_EXTENDED_FMT;
        req.misaligned = req.valid &&
          ((req.addr[3:0] & fperr_pkg::EXT_ALIGN_MASK) != 4'h0);
      end
      default: begin
        req.bytes = 10'h000;
      end
    endcase
  end

endmodule

// ---- logic/fperr_unit.sv ----
// Floating-point error recording, delivery and state save control.
//
// Function
// - Unmasked exception is recorded and drives the active-low error output.
// - Pending error is taken at next wait or float instruction, vector 16.
// - No-wait instructions run without the interrupt; error stays pending except after a no-wait save.
// - Native enable bit set selects internal vector 16 delivery.
// - Error output asserts on unmasked exceptions whatever native enable is.
// - In native mode no-wait instructions never take vector 16.
// - Legacy no-wait save with pending error pulses the error output.
// - Native delivery adds no external delay.
// - Legacy save image is 94 bytes in 16-bit, 108 in 32-bit mode.
// - Extended save image is 512 bytes, float plus SIMD state.
// - Extended save needs 16-byte alignment, else an exception.
// - Extended image uses a different tag word format and field lengths.
// - Legacy save reinitialises the unit; extended save leaves it unchanged.
// - Multiprocessor systems report exceptions only in native mode.
// - Device-not-available fault beats a pending numeric exception.
module fperr_unit (
  input wire logic clk,
  input wire logic rstn,
  input wire logic native_fault_enable,
  input wire logic multiproc,
  input wire logic task_switched,
  input wire logic instr_valid,
  input wire fperr_pkg::fperr_op_e instr_op,
  input wire logic instr_mode32,
  input wire logic [31:0] instr_addr,
  input wire logic [fperr_pkg::FLAG_W-1:0] instr_exc,
  input wire logic [fperr_pkg::FLAG_W-1:0] mask_wdata,
  input wire logic mask_we,
  input wire logic [fperr_pkg::FLAG_W-1:0] clear_flags,
  output logic float_fault_out_n,
  output logic trap_valid,
  output logic [7:0] trap_vector,
  output logic [fperr_pkg::FLAG_W-1:0] status_flags,
  output logic [fperr_pkg::FLAG_W-1:0] mask_bits,
  output logic [9:0] image_bytes,
  output logic [2:0] image_tag_fmt,
  output logic image_go,
  output logic unit_reinit,
  output logic mode_fault
);

  //////////////////////////////////////////////////////////////////////////
  // Decode and image sizing.

  fperr_if img ();

  assign img.valid = instr_valid;
  assign img.op = instr_op;
  assign img.mode32 = instr_mode32;
  assign img.addr = instr_addr;

  fperr_image u_image (
    .req(img.sink)
  );

  function automatic logic is_nowait(input fperr_pkg::fperr_op_e op);
    is_nowait = (op == fperr_pkg::FPERR_OP_NOWAIT) ||
                (op == fperr_pkg::FPERR_OP_LSAVE_NW);
  endfunction

  function automatic logic is_float(input fperr_pkg::fperr_op_e op);
    is_float = (op != fperr_pkg::FPERR_OP_NONE) &&
               (op != fperr_pkg::FPERR_OP_CLEAR);
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Exception recording.

  logic [fperr_pkg::FLAG_W-1:0] flags_q;
  logic [fperr_pkg::FLAG_W-1:0] flags_d;
  logic [fperr_pkg::FLAG_W-1:0] masks_q;
  logic pending;
  logic dna_hit;
  logic num_hit;
  logic align_hit;
  logic nowait_op;
  logic save_op;
  logic raise;

  assign nowait_op = is_nowait(instr_op);
  assign pending = |(flags_q & ~masks_q);
  assign dna_hit = instr_valid && task_switched && is_float(instr_op) &&
                   (instr_op != fperr_pkg::FPERR_OP_NOWAIT);
  // A pending error stops a waiting instruction before it runs.
  assign num_hit = instr_valid && is_float(instr_op) && !nowait_op &&
                   pending && !dna_hit;
  assign align_hit = img.misaligned && !dna_hit && !num_hit;
  assign raise = instr_valid && (instr_op == fperr_pkg::FPERR_OP_ARITH) &&
                 !dna_hit && !num_hit;
  assign save_op = (instr_op == fperr_pkg::FPERR_OP_LSAVE) ||
                   (instr_op == fperr_pkg::FPERR_OP_LSAVE_NW);

  // New exceptions win over a software clear in the same cycle.
  always_comb begin
    flags_d = flags_q & ~clear_flags;
    if (instr_valid && instr_op == fperr_pkg::FPERR_OP_CLEAR) begin
      flags_d = fperr_pkg::FLAGS_RESET;
    end
    if (instr_valid && save_op && !dna_hit && !num_hit) begin
      flags_d = fperr_pkg::FLAGS_RESET;
    end
    if (raise) begin
      flags_d = flags_d | instr_exc;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      flags_q <= fperr_pkg::FLAGS_RESET;
    end else begin
      flags_q <= flags_d;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      masks_q <= fperr_pkg::MASKS_RESET;
    end else if (mask_we) begin
      masks_q <= mask_wdata;
    end else if (instr_valid && save_op && !dna_hit && !num_hit) begin
      masks_q <= fperr_pkg::MASKS_RESET;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Error output, with a short pulse when a no-wait save meets a pending
  // error; the pending state itself is cleared by that save.

  fperr_pkg::fperr_state_e state_q;
  logic pulse_start;

  assign pulse_start = instr_valid &&
    (instr_op == fperr_pkg::FPERR_OP_LSAVE_NW) && pending && !dna_hit;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_q <= fperr_pkg::FPERR_ST_IDLE;
    end else begin
      case (state_q)
        fperr_pkg::FPERR_ST_IDLE: begin
          if (pulse_start) begin
            state_q <= fperr_pkg::FPERR_ST_PULSE;
          end
        end
        fperr_pkg::FPERR_ST_PULSE: begin
          state_q <= fperr_pkg::FPERR_ST_IDLE;
        end
        default: begin
          state_q <= fperr_pkg::FPERR_ST_IDLE;
        end
      endcase
    end
  end

  // Driven regardless of native enable, at the same point in both modes.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      float_fault_out_n <= 1'b1;
    end else begin
      float_fault_out_n <= !((|(flags_d & ~masks_q)) || pulse_start);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Trap delivery; vector 16 is raised inside the unit with no added
  // latency, so in native mode it can never drift into later code.

  always_ff @(posedge clk) begin
    if (!rstn) begin
      trap_valid <= 1'b0;
      trap_vector <= 8'h00;
    end else begin
      trap_valid <= 1'b0;
      trap_vector <= 8'h00;
      if (dna_hit) begin
        trap_valid <= 1'b1;
        trap_vector <= fperr_pkg::DNA_VECTOR;
      end else if (num_hit && native_fault_enable) begin
        trap_valid <= 1'b1;
        trap_vector <= fperr_pkg::NUMERIC_VECTOR;
      end else if (align_hit) begin
        trap_valid <= 1'b1;
        trap_vector <= fperr_pkg::ALIGN_VECTOR;
      end
    end
  end

  // Compatibility mode is refused on a multiprocessor system; the routing
  // of the error line to an interrupt controller is the system's concern.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      mode_fault <= 1'b0;
    end else begin
      mode_fault <= multiproc && !native_fault_enable;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Image transfer control.

  always_ff @(posedge clk) begin
    if (!rstn) begin
      image_go <= 1'b0;
      image_bytes <= 10'h000;
      image_tag_fmt <= fperr_pkg::TAG_LEGACY_FMT;
      unit_reinit <= 1'b0;
    end else begin
      image_go <= instr_valid && (img.bytes != 10'h000) &&
                  !dna_hit && !num_hit && !align_hit;
      image_bytes <= img.bytes;
      image_tag_fmt <= img.tag_fmt;
      unit_reinit <= instr_valid && save_op && !dna_hit && !num_hit;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      status_flags <= fperr_pkg::FLAGS_RESET;
      mask_bits <= fperr_pkg::MASKS_RESET;
    end else begin
      status_flags <= flags_d;
      mask_bits <= masks_q;
    end
  end

endmodule

// ---- tb/fperr_monitor.sv ----
// Port-level checks on the floating-point error unit.
module fperr_monitor (
  input wire logic clk,
  input wire logic rstn,
  input wire logic native_fault_enable,
  input wire logic multiproc,
  input wire logic task_switched,
  input wire logic instr_valid,
  input wire fperr_pkg::fperr_op_e instr_op,
  input wire logic instr_mode32,
  input wire logic [31:0] instr_addr,
  input wire logic [5:0] instr_exc,
  input wire logic mask_we,
  input wire logic [5:0] clear_flags,
  input wire logic float_fault_out_n,
  input wire logic trap_valid,
  input wire logic [7:0] trap_vector,
  input wire logic [5:0] mask_bits,
  input wire logic [9:0] image_bytes,
  input wire logic [2:0] image_tag_fmt,
  input wire logic image_go,
  input wire logic unit_reinit,
  input wire logic mode_fault
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  wire go = instr_valid && !task_switched;
  wire ok = go && float_fault_out_n;
  wire quiet = clear_flags == 6'h00 && !mask_we;
  a_fault_raised: assert property (go && quiet
    && instr_op == fperr_pkg::FPERR_OP_ARITH && (instr_exc & ~mask_bits) != 0
    |=> !float_fault_out_n) else $error("fault output not asserted");
  a_masked_quiet: assert property (ok && quiet
    && instr_op == fperr_pkg::FPERR_OP_ARITH && (instr_exc & ~mask_bits) == 0
    |=> float_fault_out_n && !trap_valid) else $error("masked fault seen");
  a_wait_traps: assert property (go && quiet && !float_fault_out_n
    && native_fault_enable && instr_op == fperr_pkg::FPERR_OP_WAIT
    |=> trap_valid && trap_vector == 8'h10) else $error("no numeric trap");
  a_nowait_free: assert property (go
    && instr_op == fperr_pkg::FPERR_OP_NOWAIT |=> !trap_valid)
    else $error("no-wait op trapped");
  a_dna_first: assert property (instr_valid && task_switched
    && instr_op == fperr_pkg::FPERR_OP_WAIT
    |=> trap_valid && trap_vector == 8'h07) else $error("dna not first");
  a_legacy_size: assert property (ok
    && instr_op == fperr_pkg::FPERR_OP_LSAVE |=> image_go
    && image_bytes == ($past(instr_mode32) ? 10'h06C : 10'h05E))
    else $error("legacy image size");
  a_ext_size: assert property (ok && instr_addr[3:0] == 4'h0
    && instr_op == fperr_pkg::FPERR_OP_XSAVE
    |=> image_go && image_bytes == 10'h200 && image_tag_fmt == 3'h1)
    else $error("extended image");
  a_ext_align: assert property (ok && instr_addr[3:0] != 4'h0
    && instr_op == fperr_pkg::FPERR_OP_XSAVE
    |=> trap_valid && trap_vector == 8'h0D && !image_go)
    else $error("misaligned save accepted");
  a_nowait_save: assert property (go && !float_fault_out_n
    && instr_op == fperr_pkg::FPERR_OP_LSAVE_NW
    |=> !float_fault_out_n && unit_reinit && !trap_valid)
    else $error("no-wait save pulse");
  a_fault_holds: assert property (!float_fault_out_n && quiet
    && !$past(instr_valid && instr_op == fperr_pkg::FPERR_OP_LSAVE_NW)
    && !(instr_valid && instr_op inside {fperr_pkg::FPERR_OP_LSAVE,
    fperr_pkg::FPERR_OP_LSAVE_NW, fperr_pkg::FPERR_OP_LRESTORE,
    fperr_pkg::FPERR_OP_XRESTORE, fperr_pkg::FPERR_OP_CLEAR})
    |=> !float_fault_out_n)
    else $error("fault dropped early");
  a_mode_fault: assert property (multiproc && !native_fault_enable
    |=> mode_fault) else $error("mode fault missing");
endmodule

// ---- tb/fperr_pic_model.sv ----
// Interrupt controller input for the legacy float request line.
module fperr_pic_model (
  input wire logic clk,
  input wire logic rstn,
  input wire logic irq_enable,
  input wire logic float_fault_out_n,
  output logic legacy_float_irq_line
);
  timeunit 1ns;
  timeprecision 1ns;
  // The line is only routed while irq_enable is set.
  always_ff @(posedge clk) begin
    legacy_float_irq_line <= rstn && irq_enable && !float_fault_out_n;
  end
endmodule

// ---- tb/fperr_unit_tb_top.sv ----
// Testbench for the floating-point error unit.
module fperr_unit_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rstn = 0, native_fault_enable = 1, multiproc = 0;
  logic task_switched = 0, instr_valid = 0, instr_mode32 = 0, mask_we = 0;
  logic irq_en = 0, float_fault_out_n, trap_valid, image_go, unit_reinit;
  logic mode_fault, irq;
  fperr_pkg::fperr_op_e instr_op = fperr_pkg::FPERR_OP_NONE;
  logic [31:0] instr_addr = 32'h0;
  logic [5:0] instr_exc = 6'h00, mask_wdata = 6'h00, clear_flags = 6'h00;
  logic [5:0] status_flags, mask_bits;
  logic [7:0] trap_vector;
  logic [9:0] image_bytes;
  logic [2:0] image_tag_fmt;
  int miscompares = 0, n_checks = 0;
  fperr_unit dut (.clk, .rstn, .native_fault_enable, .multiproc,
    .task_switched, .instr_valid, .instr_op, .instr_mode32, .instr_addr,
    .instr_exc, .mask_wdata, .mask_we, .clear_flags, .float_fault_out_n,
    .trap_valid, .trap_vector, .status_flags, .mask_bits, .image_bytes,
    .image_tag_fmt, .image_go, .unit_reinit, .mode_fault);
  fperr_pic_model pic (.clk, .rstn, .irq_enable(irq_en), .float_fault_out_n,
    .legacy_float_irq_line(irq));
  always #25 clk = ~clk;
  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [9:0] e, g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic op(input fperr_pkg::fperr_op_e o, input logic [5:0] x = 0,
                    input logic [31:0] a = 0, input logic m = 0);
    @(posedge clk);
    instr_valid <= 1'b1;
    instr_op <= o;
    instr_exc <= x;
    instr_addr <= a;
    instr_mode32 <= m;
    @(posedge clk);
    instr_valid <= 1'b0;
    #1;
  endtask
  task automatic ctl(input logic [5:0] c, input logic w, input logic [5:0] m);
    @(posedge clk);
    clear_flags <= c;
    mask_we <= w;
    mask_wdata <= m;
    @(posedge clk);
    clear_flags <= 6'h00;
    mask_we <= 1'b0;
    #1;
  endtask
  task automatic t_native;
    ctl(6'h00, 1'b1, 6'h3E);
    op(fperr_pkg::FPERR_OP_ARITH, 6'h01);
    chk("fault_n", 0, float_fault_out_n);
    op(fperr_pkg::FPERR_OP_NOWAIT);
    chk("nowait trap", 0, trap_valid);
    op(fperr_pkg::FPERR_OP_WAIT);
    chk("trap", 1, trap_valid);
    chk("vector", 10'h010, trap_vector);
    ctl(6'h01, 1'b0, 6'h00);
    chk("fault_n", 1, float_fault_out_n);
    op(fperr_pkg::FPERR_OP_ARITH, 6'h02);
    chk("masked fault_n", 1, float_fault_out_n);
    chk("flags", 10'h002, status_flags);
    ctl(6'h02, 1'b0, 6'h00);
    op(fperr_pkg::FPERR_OP_ARITH, 6'h01);
    chk("fault_n", 0, float_fault_out_n);
    op(fperr_pkg::FPERR_OP_CLEAR);
    chk("clear fault_n", 1, float_fault_out_n);
  endtask
  task automatic t_dna;
    op(fperr_pkg::FPERR_OP_ARITH, 6'h01);
    task_switched <= 1'b1;
    op(fperr_pkg::FPERR_OP_WAIT);
    chk("dna vector", 10'h007, trap_vector);
    task_switched <= 1'b0;
    op(fperr_pkg::FPERR_OP_WAIT);
    chk("later vector", 10'h010, trap_vector);
  endtask
  task automatic t_compat;
    @(posedge clk);
    native_fault_enable <= 1'b0;
    irq_en <= 1'b1;
    op(fperr_pkg::FPERR_OP_WAIT);
    chk("blocked trap", 0, trap_valid);
    chk("irq", 1, irq);
    op(fperr_pkg::FPERR_OP_LSAVE_NW);
    chk("pulse", 0, float_fault_out_n);
    chk("reinit", 1, unit_reinit);
    @(posedge clk);
    #1;
    chk("pulse end", 1, float_fault_out_n);
    chk("masks", 10'h03F, mask_bits);
    native_fault_enable <= 1'b1;
    irq_en <= 1'b0;
  endtask
  task automatic t_images;
    for (int m = 0; m < 2; m++) begin
      op(fperr_pkg::FPERR_OP_LSAVE, 0, 0, m[0]);
      chk("legacy", m ? 10'h06C : 10'h05E, image_bytes);
      chk("legacy tag", 0, image_tag_fmt);
    end
    op(fperr_pkg::FPERR_OP_XSAVE, 0, 32'h100);
    chk("ext", 10'h200, image_bytes);
    chk("ext tag", 1, image_tag_fmt);
    op(fperr_pkg::FPERR_OP_XSAVE, 0, 32'h108);
    chk("align", 10'h00D, trap_vector);
    chk("align go", 0, image_go);
    op(fperr_pkg::FPERR_OP_XRESTORE, 0, 32'h110);
    chk("ext restore", 10'h200, image_bytes);
    chk("ext restore go", 1, image_go);
    op(fperr_pkg::FPERR_OP_LRESTORE, 0, 0, 1'b1);
    chk("legacy restore", 10'h06C, image_bytes);
    chk("restore reinit", 0, unit_reinit);
    multiproc <= 1'b1;
    native_fault_enable <= 1'b0;
    ctl(6'h00, 1'b0, 6'h00);
    chk("mode", 1, mode_fault);
  endtask
  task automatic results;
    if (miscompares == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    #1;
    chk("reset masks", 10'h03F, mask_bits);
    t_native();
    t_dna();
    ctl(6'h01, 1'b0, 6'h00);
    op(fperr_pkg::FPERR_OP_ARITH, 6'h01);
    t_compat();
    t_images();
    results();
  end
  initial begin
    #100us;
    miscompares++;
    results();
  end
endmodule
bind fperr_unit fperr_monitor mon (.clk, .rstn, .native_fault_enable,
  .multiproc, .task_switched, .instr_valid, .instr_op, .instr_mode32,
  .instr_addr, .instr_exc, .mask_we, .clear_flags, .float_fault_out_n,
  .trap_valid, .trap_vector, .mask_bits, .image_bytes, .image_tag_fmt,
  .image_go, .unit_reinit, .mode_fault);
